// ==== usp_pkg.sv ====
// Package of constants and carrier types for the UPS status panel
package usp_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    // Horn cadence: half a second on, half a second off
    localparam int unsigned HORN_HALF_MS    = 500;
    localparam int unsigned HORN_HALF_CYC   = CLK_HZ / 1000 * HORN_HALF_MS;
    // Lamp flash and top-line blink share the horn cadence
    localparam int unsigned BLANK_MIN       = 30;
    localparam int unsigned BLANK_SEC       = BLANK_MIN * 60;
    localparam int unsigned CHARGE_HOURS    = 24;
    localparam int unsigned CHARGE_SEC      = CHARGE_HOURS * 3600;
    localparam int unsigned SCROLL_SEC      = 3;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned SEC_CYC         = CLK_HZ;
    localparam logic [7:0]  RUNTIME_INIT_MIN = 8'h02;

    localparam int unsigned NUM_BUTTONS     = 8;

    // Status line items in scroll order
    typedef enum logic [2:0] {
        USP_LINE_MODEL,
        USP_LINE_CLOCK,
        USP_LINE_ALARMS,
        USP_LINE_NOTICES,
        USP_LINE_LOAD,
        USP_LINE_ENV
    } usp_line_t;

    // Panel screens
    typedef enum logic [2:0] {
        USP_SCR_LOGO,
        USP_SCR_MIMIC,
        USP_SCR_EVENTS,
        USP_SCR_METERS,
        USP_SCR_CONTROLS,
        USP_SCR_SETUP
    } usp_screen_t;

    // Message categories
    typedef enum logic [1:0] {
        USP_CAT_ALARM,
        USP_CAT_NOTICE,
        USP_CAT_STATUS,
        USP_CAT_COMMAND
    } usp_cat_t;

    // Operating mode inputs from the UPS
    typedef struct packed {
        logic online;
        logic battery;
        logic bypass;
        logic off;
    } usp_mode_t;

    // Event message presented by the UPS
    typedef struct packed {
        logic       valid;
        usp_cat_t   cat;
        logic       horn;
        logic       history;
        logic [7:0] code;
    } usp_event_t;

    // Lamp outputs
    typedef struct packed {
        logic online;
        logic battery;
        logic bypass;
        logic alarm;
    } usp_lamps_t;

endpackage

// ==== usp_panel.sv ====
// UPS front-panel annunciator: lamps, horn, status line, screens and blanking
`timescale 1ns/1ps

module usp_panel
    import usp_pkg::*;
#(
    parameter int unsigned NB            = NUM_BUTTONS,
    parameter int unsigned HALF_CYC      = HORN_HALF_CYC,
    parameter int unsigned SECOND_CYC    = SEC_CYC,
    parameter int unsigned DEB_CYC       = DEBOUNCE_CYC,
    parameter int unsigned BLANK_S       = BLANK_SEC,
    parameter int unsigned CHARGE_S      = CHARGE_SEC,
    parameter int unsigned SCROLL_S      = SCROLL_SEC
) (
    input  wire logic        I_CORE_CLK,       // 20 MHz system clock
    input  wire logic        I_RESET_N,        // Async power-up reset, active low
    input  wire logic [NB-1:0] I_BUTTON,       // Raw pushbuttons, high when pressed
    input  wire usp_mode_t   I_MODE,           // UPS operating mode
    input  wire logic        I_ALARM_ACTIVE,   // Any alarm currently active
    input  wire logic [7:0]  I_TOP_ALARM,      // Highest-priority active alarm code
    input  wire logic        I_NOTICE_ACTIVE,  // Any notice currently active
    input  wire logic        I_COMMAND_ACTIVE, // Any command currently active
    input  wire usp_event_t  I_EVENT,          // Event message, valid one cycle
    input  wire logic        I_PROBE_FITTED,   // Environment probe installed
    input  wire logic        I_TEST_DONE,      // Battery test finished pulse
    input  wire logic [7:0]  I_TEST_RUNTIME,   // Measured runtime, minutes
    output usp_lamps_t       O_LAMPS,          // Lamp drive
    output logic             O_HORN,           // Horn drive
    output logic             O_DISP_ON,        // Display backlight on
    output logic             O_TOP_BLINK_OFF,  // Top line blanked this phase
    output usp_line_t        O_LINE,           // Current status line item
    output logic [7:0]       O_LINE_ALARM,     // Alarm code shown on status line
    output usp_screen_t      O_SCREEN,         // Current screen
    output usp_event_t       O_MSG,            // Last event in status area
    output logic             O_LOG_ACTIVE,     // Write message to active events list
    output logic             O_LOG_HISTORY,    // Write message to history
    output logic             O_LIST_EVENTS,    // Events screen listing request
    output logic [NB-1:0]    O_NAV_PRESS,      // Navigation press to screen logic
    output logic             O_START_TEST,     // Start battery test pulse
    output logic [7:0]       O_RUNTIME         // Reported runtime, minutes
);

    ////////////////////////////////////////////////////////////////////////////
    // Counter widths

    // Widths follow the parameters, so a longer override cannot wrap a counter
    localparam int unsigned DEB_W    = $clog2(DEB_CYC + 1);
    localparam int unsigned HALF_W   = $clog2(HALF_CYC + 1);
    localparam int unsigned SEC_W    = $clog2(SECOND_CYC + 1);
    localparam int unsigned SCROLL_W = $clog2(SCROLL_S + 1);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [NB-1:0] sync1;
        logic [NB-1:0] sync2;
        logic [NB-1:0] stable;
        logic [NB-1:0][DEB_W-1:0] deb;
        logic [HALF_W-1:0] half_cnt;
        logic          phase;
        logic [SEC_W-1:0] sec_cnt;
        logic [31:0]   idle_s;
        logic [31:0]   charge_s;
        logic          tested;
        logic [SCROLL_W-1:0] scroll_s;
        logic          alarm_q;
        logic          unacked;
        logic          horn_req;
        usp_lamps_t    lamps;
        logic          horn;
        logic          disp_on;
        logic          blink_off;
        usp_line_t     line;
        logic [7:0]    line_alarm;
        usp_screen_t   screen;
        usp_event_t    msg;
        logic          log_active;
        logic          log_history;
        logic          list_events;
        logic [NB-1:0] nav;
        logic          start_test;
        logic [7:0]    runtime;
    } usp_state_t;

    usp_state_t s;
    usp_state_t next_s;

    logic [NB-1:0] press;
    logic          any_press;
    logic          sec_tick;
    logic          attention;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;

        next_s.sync1 = I_BUTTON;
        next_s.sync2 = s.sync1;

        press = '0;
        for (int i = 0; i < NB; i++) begin
            if (s.sync2[i] == s.stable[i]) begin
                next_s.deb[i] = '0;
            end else if (32'(s.deb[i]) >= DEB_CYC - 1) begin
                next_s.deb[i]    = '0;
                next_s.stable[i] = s.sync2[i];
                press[i]         = s.sync2[i];
            end else begin
                next_s.deb[i] = s.deb[i] + 1'b1;
            end
        end
        any_press = |press;

        // Free-running timebase shared by horn, red-lamp flash and top-line blink
        // Half-second cadence
        if (32'(s.half_cnt) >= HALF_CYC - 1) begin
            next_s.half_cnt = '0;
            next_s.phase    = ~s.phase;
        end else begin
            next_s.half_cnt = s.half_cnt + 1'b1;
        end

        // One-second tick for scroll, idle and charge timers
        sec_tick = 32'(s.sec_cnt) >= SECOND_CYC - 1;
        if (sec_tick) begin
            next_s.sec_cnt = '0;
        end else begin
            next_s.sec_cnt = s.sec_cnt + 1'b1;
        end

        next_s.lamps.online  = !I_MODE.off && !I_MODE.bypass && (I_MODE.online || I_MODE.battery);
        next_s.lamps.battery = !I_MODE.off && I_MODE.battery;
        next_s.lamps.bypass  = !I_MODE.off && I_MODE.bypass;

        // A press in the same cycle as a new alarm must not hide it
        // New alarm latch; set wins over ack
        next_s.alarm_q = I_ALARM_ACTIVE;
        if (I_ALARM_ACTIVE && !s.alarm_q) begin
            next_s.unacked = 1'b1;
        end else if (any_press || !I_ALARM_ACTIVE) begin
            next_s.unacked = 1'b0;
        end

        // Steady while active, flashing while new
        next_s.lamps.alarm = I_ALARM_ACTIVE && !(s.unacked && s.phase);
        next_s.line_alarm  = I_TOP_ALARM;

        if ((I_ALARM_ACTIVE && !s.alarm_q) || (I_EVENT.valid && I_EVENT.horn)) begin
            next_s.horn_req = 1'b1;
        end else if (any_press) begin
            next_s.horn_req = 1'b0;
        end
        next_s.horn = s.horn_req && !s.phase;

        // Status area keeps the last message until another event arrives
        // Status message and logging
        next_s.log_active  = I_EVENT.valid;
        next_s.log_history = I_EVENT.valid && I_EVENT.history;
        if (I_EVENT.valid) begin
            next_s.msg = I_EVENT;
        end

        // Idle count saturates, so the display stays dark until a press
        // Idle blanking; waking press is consumed
        next_s.nav = '0;
        if (any_press) begin
            next_s.idle_s  = '0;
            next_s.disp_on = 1'b1;
        end else if (sec_tick) begin
            if (s.idle_s >= BLANK_S - 1) begin
                next_s.disp_on = 1'b0;
            end else begin
                next_s.idle_s = s.idle_s + 1;
            end
        end

        if (sec_tick) begin
            if (32'(s.scroll_s) >= SCROLL_S - 1) begin
                next_s.scroll_s = '0;
                unique case (s.line)
                    USP_LINE_MODEL:   next_s.line = USP_LINE_CLOCK;
                    USP_LINE_CLOCK:   next_s.line = USP_LINE_ALARMS;
                    USP_LINE_ALARMS:  next_s.line = USP_LINE_NOTICES;
                    USP_LINE_NOTICES: next_s.line = USP_LINE_LOAD;
                    USP_LINE_LOAD:    next_s.line = I_PROBE_FITTED ? USP_LINE_ENV : USP_LINE_MODEL;
                    USP_LINE_ENV:     next_s.line = USP_LINE_MODEL;
                    default:          next_s.line = USP_LINE_MODEL;
                endcase
            end else begin
                next_s.scroll_s = s.scroll_s + 1'b1;
            end
        end

        attention        = I_ALARM_ACTIVE || s.horn_req || s.unacked;
        next_s.blink_off = attention && s.phase;

        // A press that only wakes the display changes no screen
        // Logo then mimic
        // Buttons 0..3 select screens, 4 escapes, rest navigate
        if (any_press && s.disp_on) begin
            if (s.screen == USP_SCR_LOGO) begin
                next_s.screen = USP_SCR_MIMIC;
            end else if (press[0]) begin
                next_s.screen = USP_SCR_EVENTS;
            end else if (press[1]) begin
                next_s.screen = USP_SCR_METERS;
            end else if (press[2]) begin
                next_s.screen = USP_SCR_CONTROLS;
            end else if (press[3]) begin
                next_s.screen = USP_SCR_SETUP;
            end else if (press[4]) begin
                next_s.screen = USP_SCR_MIMIC;
            end else begin
                next_s.nav = press;
            end
        end

        next_s.list_events = (s.screen == USP_SCR_EVENTS)
                             && (I_ALARM_ACTIVE || I_NOTICE_ACTIVE || I_COMMAND_ACTIVE);

        // Runtime keeps its startup figure until the self test reports
        // Initial runtime, self test after charging
        next_s.start_test = 1'b0;
        if (!s.tested && sec_tick) begin
            if (s.charge_s >= CHARGE_S - 1) begin
                next_s.tested     = 1'b1;
                next_s.start_test = 1'b1;
            end else begin
                next_s.charge_s = s.charge_s + 1;
            end
        end
        if (I_TEST_DONE && s.tested) begin
            next_s.runtime = I_TEST_RUNTIME;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset leaves the display lit on the logo screen with the startup runtime
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s         <= '0;
            s.disp_on <= 1'b1;
            s.screen  <= USP_SCR_LOGO;
            s.line    <= USP_LINE_MODEL;
            s.runtime <= RUNTIME_INIT_MIN;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign O_LAMPS         = s.lamps;
    assign O_HORN          = s.horn;
    assign O_DISP_ON       = s.disp_on;
    assign O_TOP_BLINK_OFF = s.blink_off;
    assign O_LINE          = s.line;
    assign O_LINE_ALARM    = s.line_alarm;
    assign O_SCREEN        = s.screen;
    assign O_MSG           = s.msg;
    assign O_LOG_ACTIVE    = s.log_active;
    assign O_LOG_HISTORY   = s.log_history;
    assign O_LIST_EVENTS   = s.list_events;
    assign O_NAV_PRESS     = s.nav;
    assign O_START_TEST    = s.start_test;
    assign O_RUNTIME       = s.runtime;

endmodule

// ==== usp_panel_props.sv ====
// Port assertions for the status panel, bound into usp_panel
`timescale 1ns/1ps
module usp_panel_props
    import usp_pkg::*;
#(
    parameter int unsigned NB       = NUM_BUTTONS,
    parameter int unsigned HALF_CYC = HORN_HALF_CYC
) (
    input wire logic          I_CORE_CLK,     // Clock
    input wire logic          I_RESET_N,      // Reset
    input wire usp_mode_t     I_MODE,         // Mode
    input wire logic          I_ALARM_ACTIVE, // Alarm
    input wire usp_event_t    I_EVENT,        // Event
    input wire logic          I_PROBE_FITTED, // Probe
    input wire logic          I_TEST_DONE,    // Test done
    input wire logic [7:0]    I_TEST_RUNTIME, // Runtime in
    input wire usp_lamps_t    O_LAMPS,        // Lamps
    input wire logic          O_HORN,         // Horn
    input wire usp_line_t     O_LINE,         // Line item
    input wire usp_event_t    O_MSG,          // Message
    input wire logic          O_LOG_ACTIVE,   // Active log
    input wire logic          O_LOG_HISTORY,  // History log
    input wire logic [NB-1:0] O_NAV_PRESS,    // Nav press
    input wire logic          O_START_TEST,   // Test start
    input wire logic [7:0]    O_RUNTIME       // Runtime out
);
    logic [15:0] hi_run;

    default clocking dcb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    // Length of the current horn-on run, so cadence is checked without long repetition
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            hi_run <= 16'h0000;
        end else begin
            hi_run <= O_HORN ? hi_run + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////
    lamp_online_a: assert property ($past(I_RESET_N) |->
        O_LAMPS.online == (($past(I_MODE.online) || $past(I_MODE.battery))
        && !$past(I_MODE.bypass) && !$past(I_MODE.off))) else $error("online lamp wrong");
    lamp_battery_a: assert property ($past(I_RESET_N) && $past(I_MODE.battery) |->
        O_LAMPS.battery) else $error("battery lamp dark");
    lamp_bypass_a: assert property ($past(I_RESET_N) && $past(I_MODE.bypass) |->
        O_LAMPS.bypass) else $error("bypass lamp dark");
    alarm_lamp_cause_a: assert property (O_LAMPS.alarm |-> $past(I_ALARM_ACTIVE))
        else $error("alarm lamp without alarm");
    alarm_lamp_rise_a: assert property ($rose(I_ALARM_ACTIVE) |-> ##[1:20] O_LAMPS.alarm)
        else $error("alarm lamp late");
    horn_start_a: assert property ($rose(I_ALARM_ACTIVE) |-> ##[1:20] O_HORN)
        else $error("horn late");
    horn_cadence_a: assert property (O_HORN |-> hi_run < HALF_CYC)
        else $error("horn on too long");
    event_log_a: assert property (I_EVENT.valid |=> O_LOG_ACTIVE && O_MSG.code == $past(I_EVENT.code)
        && O_MSG.cat == $past(I_EVENT.cat) && O_LOG_HISTORY == $past(I_EVENT.history))
        else $error("event not logged");
    line_env_a: assert property ($changed(O_LINE) && O_LINE == USP_LINE_ENV |-> $past(I_PROBE_FITTED))
        else $error("env item without probe");
    test_pulse_a: assert property (O_START_TEST |=> !O_START_TEST)
        else $error("test start not a pulse");
    runtime_upd_a: assert property ($changed(O_RUNTIME) |->
        $past(I_TEST_DONE) && O_RUNTIME == $past(I_TEST_RUNTIME)) else $error("runtime changed alone");
    nav_pulse_a: assert property (|O_NAV_PRESS |=> !(|O_NAV_PRESS))
        else $error("nav press too long");
endmodule

bind usp_panel usp_panel_props #(.HALF_CYC(HALF_CYC)) u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_MODE(I_MODE),
    .I_ALARM_ACTIVE(I_ALARM_ACTIVE), .I_EVENT(I_EVENT), .I_PROBE_FITTED(I_PROBE_FITTED),
    .I_TEST_DONE(I_TEST_DONE), .I_TEST_RUNTIME(I_TEST_RUNTIME), .O_LAMPS(O_LAMPS),
    .O_HORN(O_HORN), .O_LINE(O_LINE), .O_MSG(O_MSG), .O_LOG_ACTIVE(O_LOG_ACTIVE),
    .O_LOG_HISTORY(O_LOG_HISTORY), .O_NAV_PRESS(O_NAV_PRESS), .O_START_TEST(O_START_TEST),
    .O_RUNTIME(O_RUNTIME)
);

// ==== usp_operator.sv ====
// Operator model: presses panel pushbuttons with contact bounce
`timescale 1ns/1ps
module usp_operator
    import usp_pkg::*;
#(
    parameter int unsigned NB  = NUM_BUTTONS,
    // Hold margin is sized for the bench's shortened debounce
    parameter int unsigned DEB = 3
) (
    input  wire logic     i_clk,    // Panel clock
    output logic [NB-1:0] o_button  // Raw buttons
);
    initial begin
        o_button = {NB{1'b0}};
    end

    task automatic press(input int unsigned idx);
        repeat (2) begin
            @(negedge i_clk) o_button[idx] = 1'b1;
            @(negedge i_clk) o_button[idx] = 1'b0;
        end
        @(negedge i_clk) o_button[idx] = 1'b1;
        repeat (DEB + 8) @(negedge i_clk);
        o_button[idx] = 1'b0;
        @(negedge i_clk) o_button[idx] = 1'b1;
        @(negedge i_clk) o_button[idx] = 1'b0;
        repeat (DEB + 8) @(negedge i_clk);
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the UPS status panel
`timescale 1ns/1ps
module tb;
    import usp_pkg::*;
    localparam int unsigned HC = 8;
    localparam int unsigned SC = 10;
    logic        clk = 1'b0;
    logic        rst_n, alarm, probe, done, horn, disp, blink, log_a, log_h, list, start, note, cmd;
    logic [7:0]  btn, rt, nav, runtime, top_alarm, line_alarm;
    usp_mode_t   mode;
    usp_event_t  ev, msg;
    usp_lamps_t  lamps;
    usp_line_t   line;
    usp_screen_t scr;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          n_nav = 0, n_start = 0, cyc = 0, start_cyc = 0;

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nav[6] === 1'b1) begin
            n_nav <= n_nav + 1;
        end
        if (start === 1'b1) begin
            n_start <= n_start + 1;
            start_cyc <= cyc;
        end
    end

    // Blanking and scroll keep their real second counts; the second, horn half-cycle, debounce and charge wait (5 s) are shortened
    usp_operator op (.i_clk(clk), .o_button(btn));
    usp_panel #(.HALF_CYC(HC), .SECOND_CYC(SC), .DEB_CYC(3), .CHARGE_S(5)) uut (.I_CORE_CLK(clk),
        .I_RESET_N(rst_n), .I_BUTTON(btn), .I_MODE(mode), .I_ALARM_ACTIVE(alarm), .I_TOP_ALARM(top_alarm),
        .I_NOTICE_ACTIVE(note), .I_COMMAND_ACTIVE(cmd), .I_EVENT(ev), .I_PROBE_FITTED(probe),
        .I_TEST_DONE(done), .I_TEST_RUNTIME(rt), .O_LAMPS(lamps), .O_HORN(horn), .O_DISP_ON(disp),
        .O_TOP_BLINK_OFF(blink), .O_LINE(line), .O_LINE_ALARM(line_alarm), .O_SCREEN(scr), .O_MSG(msg),
        .O_LOG_ACTIVE(log_a), .O_LOG_HISTORY(log_h), .O_LIST_EVENTS(list), .O_NAV_PRESS(nav),
        .O_START_TEST(start), .O_RUNTIME(runtime));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Waits while the horn holds level v, counting cycles into n
    task automatic run(input logic v, inout int n);
        while (horn === v && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_runtime;
        int n;
        n = 0;
        chk(runtime, 8'h02);
        while (n_start == 0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(start_cyc >= 60, 1'b1);
        chk(runtime, 8'h02);
        rt = 8'h2D;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        @(negedge clk);
        chk(runtime, 8'h2D);
    endtask

    task automatic t_lamps;
        logic [3:0] m [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
        logic [3:0] e [4] = '{4'h8, 4'hC, 4'h2, 4'h0};
        for (int i = 0; i < 4; i++) begin
            mode = m[i];
            repeat (2) @(negedge clk);
            chk(lamps, e[i]);
        end
        mode = 4'h8;
    endtask

    task automatic t_screens;
        usp_screen_t s [5] = '{USP_SCR_EVENTS, USP_SCR_METERS, USP_SCR_CONTROLS, USP_SCR_SETUP, USP_SCR_MIMIC};
        int n0;
        op.press(6);
        chk(scr, USP_SCR_MIMIC);
        for (int i = 0; i < 5; i++) begin
            op.press(i);
            chk(scr, s[i]);
            chk(list, 1'b0);
            cmd = 1'b1;
            repeat (2) @(negedge clk);
            chk(list, i == 0);
            cmd = 1'b0;
            note = 1'b1;
            repeat (2) @(negedge clk);
            chk(list, i == 0);
            note = 1'b0;
        end
        n0 = n_nav;
        op.press(6);
        chk(n_nav - n0, 1);
        chk(scr, USP_SCR_MIMIC);
    endtask

    task automatic t_alarm;
        int n;
        logic ok;
        n = 0;
        ok = 1'b1;
        alarm = 1'b1;
        top_alarm = 8'h5A;
        run(1'b0, n);
        run(1'b1, n);
        repeat (3) @(negedge clk);
        chk(lamps.alarm, 1'b0);
        chk(blink, 1'b1);
        chk(line_alarm, 8'h5A);
        n = 3;
        run(1'b0, n);
        chk(n, HC);
        n = 0;
        run(1'b1, n);
        chk(n, HC);
        op.press(7);
        repeat (2 * HC) begin
            @(negedge clk);
            ok = ok & (horn === 1'b0) & (lamps.alarm === 1'b1);
        end
        chk(ok, 1'b1);
        alarm = 1'b0;
        repeat (2) @(negedge clk);
        chk(lamps.alarm, 1'b0);
    endtask

    task automatic t_events;
        int n;
        for (int c = 0; c < 4; c++) begin
            ev = {1'b1, 2'(c), 1'b0, c[0], 8'h10 + 8'(c)};
            @(negedge clk);
            ev.valid = 1'b0;
            chk(log_a, 1'b1);
            chk(log_h, c[0]);
            chk({msg.cat, msg.code}, {2'(c), 8'h10 + 8'(c)});
            @(negedge clk);
        end
        // A notice that asks for the horn, silenced by one press
        ev = {1'b1, USP_CAT_NOTICE, 1'b1, 1'b0, 8'h20};
        @(negedge clk);
        ev.valid = 1'b0;
        n = 0;
        run(1'b0, n);
        chk(horn, 1'b1);
        op.press(7);
        chk(horn, 1'b0);
    endtask

    task automatic t_scroll(input logic p, input logic [7:0] exp);
        logic       steady;
        logic [7:0] seen;
        steady = 1'b1;
        probe = p;
        seen = 8'h00;
        repeat (200) begin
            @(negedge clk);
            steady = steady & (blink === 1'b0);
            seen[line] = 1'b1;
        end
        chk(seen, exp);
        chk(steady, 1'b1);
    endtask

    task automatic t_blank;
        int n;
        n = 0;
        chk(disp, 1'b1);
        while (disp === 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk(disp, 1'b0);
        chk(n > 17000, 1'b1);
        op.press(0);
        chk(disp, 1'b1);
        chk(scr, USP_SCR_MIMIC);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        mode = 4'h8;
        alarm = 1'b0;
        top_alarm = 8'h00;
        note = 1'b0;
        cmd = 1'b0;
        ev = 13'h0000;
        probe = 1'b0;
        done = 1'b0;
        rt = 8'h00;
        repeat (16) @(negedge clk);
        chk(scr, USP_SCR_LOGO);
        rst_n = 1'b1;
        t_runtime();
        t_lamps();
        t_screens();
        t_alarm();
        t_events();
        t_scroll(1'b0, 8'h1F);
        op.press(5);
        t_scroll(1'b1, 8'h3F);
        t_blank();
        chk(n_start, 1);
        final_report();
    end

    // The sequence needs about 19000 cycles, mostly the blanking wait; twice that means a hang
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule
